// ---- rtl/margin_pkg.sv ----
// constants, field layout and types of the margining dac control block
// assumes a 50 MHz ref_clk and a word-addressed avalon-mm register slave
package margin_pkg;

   // ==========================================================
   // channel count and code arithmetic
   localparam int NUM_CH = 6;
   localparam logic [7:0] MID_CODE = 8'h7F;
   localparam int CODE_SPAN = 255;
   localparam int SWING_UV = 601500;
   // swing from midcode at code 0xFF and at code 0x00, truncated to whole uV
   localparam logic [20:0] TOP_SWING_UV = 21'h49B69;
   localparam logic [20:0] BOTTOM_SWING_UV = 21'h49232;

   // ==========================================================
   // midcode voltages of the four ranges, in uV
   localparam logic [20:0] MID_0V6_UV = 21'h927C0;
   localparam logic [20:0] MID_0V8_UV = 21'hC3500;
   localparam logic [20:0] MID_1V0_UV = 21'hF4240;
   localparam logic [20:0] MID_1V25_UV = 21'h1312D0;

   // ==========================================================
   // buffer power-up tracking time
   localparam int CLK_PERIOD_NS = 20;
   localparam int TRACK_TIME_NS = 10000;
   localparam int TRACK_CYCLES = (TRACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] TRACK_LAST = 9'(TRACK_CYCLES - 1);

   // ==========================================================
   // register map: word index = channel*4 + field
   localparam int ADDR_W = 5;
   localparam logic [1:0] FLD_CODE = 2'h0;
   localparam logic [1:0] FLD_LOWER = 2'h1;
   localparam logic [1:0] FLD_UPPER = 2'h2;
   localparam logic [1:0] FLD_CTRL = 2'h3;
   localparam logic [4:0] STATUS_INDEX = 5'h18;
   localparam int CTRL_RANGE_LSB = 0;
   localparam int CTRL_ENABLE_BIT = 2;
   localparam int CTRL_MARGIN_BIT = 3;
   localparam int STAT_DRIVE_LSB = 0;
   localparam int STAT_HIZ_LSB = 8;
   localparam int STAT_MARGIN_LSB = 16;
   localparam int STAT_CLIP_LSB = 24;

   // ==========================================================
   // values after reset
   localparam logic [7:0] CODE_RST = 8'h7F;
   localparam logic [7:0] LOWER_RST = 8'h00;
   localparam logic [7:0] UPPER_RST = 8'hFF;
   localparam logic [1:0] RANGE_RST = 2'h0;
   localparam logic [20:0] LEVEL_RST = MID_0V6_UV;

   // buffer sequence, gray along off -> track -> drive
   typedef enum logic [1:0] {
      BUF_OFF = 2'h0,
      BUF_TRACK = 2'h1,
      BUF_DRIVE = 2'h3
   } buf_state_t;

   // midcode voltage of a range select
   function automatic logic [20:0] mid_uv(input logic [1:0] sel);
      logic [20:0] v;
      v = MID_0V6_UV;
      unique case (sel)
         2'h0: v = MID_0V6_UV;
         2'h1: v = MID_0V8_UV;
         2'h2: v = MID_1V0_UV;
         2'h3: v = MID_1V25_UV;
      endcase
      return v;
   endfunction

endpackage

// ---- rtl/dac_level_if.sv ----
// carries one channel's applied code and range to its level converter
// assumes margin_pkg is compiled first
`timescale 1ns/100ps
interface dac_level_if;
   logic [7:0] code;
   logic [1:0] range_sel;
   logic [20:0] level_uv;
   modport src(output code, output range_sel, input level_uv);
   modport conv(input code, input range_sel, output level_uv);
endinterface

// ---- rtl/dac_level.sv ----
// converts an applied dac code and range into the output level in uV
// assumes code and range come from registers in the ref_clk domain
`timescale 1ns/100ps
module dac_level
   import margin_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   dac_level_if.conv lvl
);

   typedef struct packed {
      logic [20:0] level;
   } lvl_state_t;

   lvl_state_t r;
   lvl_state_t next_r;

   // ==========================================================
   // linear transfer around the selected midcode
   always_comb begin
      logic signed [9:0] diff;
      logic signed [31:0] prod;
      logic signed [31:0] step;
      diff = $signed({2'b00, lvl.code}) - $signed({2'b00, MID_CODE});
      prod = 32'(diff) * 32'(SWING_UV);
      step = prod / 32'(CODE_SPAN); // truncates toward zero
      next_r.level = 21'($signed({11'h000, mid_uv(lvl.range_sel)}) + step);
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         r.level <= LEVEL_RST;
      end else begin
         r <= next_r;
      end
   end

   assign lvl.level_uv = r.level;

   // ==========================================================
   // checks on the transfer
   chk_mid_level: assert property (@(posedge ref_clk) disable iff (!nrst)
      lvl.code == MID_CODE |=> r.level == mid_uv($past(lvl.range_sel)))
      else $error("midcode does not sit at the range offset");

   chk_top_swing: assert property (@(posedge ref_clk) disable iff (!nrst)
      lvl.code == 8'hFF |=> r.level == mid_uv($past(lvl.range_sel)) + TOP_SWING_UV)
      else $error("top code swing is wrong");

   chk_bottom_swing: assert property (@(posedge ref_clk) disable iff (!nrst)
      lvl.code == 8'h00 |=> r.level == mid_uv($past(lvl.range_sel)) - BOTTOM_SWING_UV)
      else $error("bottom code swing is wrong");

endmodule

// ---- rtl/margining_dac_control.sv ----
// six-channel margining dac control: registers, clipping, margin select,
// glitch-free buffer enable sequence
// assumes avalon-mm master in the ref_clk domain, margin pins synchronous
`timescale 1ns/100ps

module margining_dac_control
   import margin_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic margin_up_input,
   input wire logic margin_down_input,
   output logic [NUM_CH-1:0][7:0] dac_code,
   output logic [NUM_CH-1:0][20:0] dac_level_uv,
   output logic [NUM_CH-1:0] buf_track,
   output logic [NUM_CH-1:0] buf_sel_dac,
   output logic [NUM_CH-1:0] buf_drive
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [NUM_CH-1:0][7:0] channel_code_register;
      logic [NUM_CH-1:0][7:0] lower_code_limit;
      logic [NUM_CH-1:0][7:0] upper_code_limit;
      logic [NUM_CH-1:0][1:0] range_sel;
      logic [NUM_CH-1:0] enable;
      logic [NUM_CH-1:0] margin_sel;
      buf_state_t [NUM_CH-1:0] buf_st;
      logic [NUM_CH-1:0][8:0] timer;
      logic [NUM_CH-1:0][7:0] applied;
      logic [NUM_CH-1:0] clipped;
      logic [NUM_CH-1:0] margin_act;
      logic ack;
      logic [31:0] rdata;
   } ctl_state_t;

   ctl_state_t r;
   ctl_state_t next_r;

   // channel number and range check of a word index, used by read and write
   function automatic logic [2:0] chan_of(input logic [ADDR_W-1:0] a);
      return a[4:2];
   endfunction

   function automatic logic is_chan(input logic [ADDR_W-1:0] a);
      return a < STATUS_INDEX;
   endfunction

   // code clipped into [lo, hi]; lo is tested first
   function automatic logic [7:0] clip(input logic [7:0] c, input logic [7:0] lo,
                                       input logic [7:0] hi);
      logic [7:0] v;
      v = c;
      if (c < lo) begin
         v = lo;
      end else if (c > hi) begin
         v = hi;
      end
      return v;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      logic [2:0] ch;
      logic [31:0] rd;
      logic [7:0] target;
      logic up;
      logic dn;
      logic ok;
      logic [NUM_CH-1:0] drive_v;
      logic [NUM_CH-1:0] hiz_v;
      ch = 3'h0;
      rd = 32'h0000_0000;
      target = 8'h00;
      up = 1'b0;
      dn = 1'b0;
      ok = 1'b0;
      drive_v = '0;
      hiz_v = '0;
      next_r = r;

      // every request waits exactly one cycle, then is answered
      next_r.ack = (avs_read | avs_write) & ~r.ack;

      // per-channel code path and buffer sequence
      for (int i = 0; i < NUM_CH; i++) begin
         hiz_v[i] = r.lower_code_limit[i] > r.upper_code_limit[i];
         drive_v[i] = r.buf_st[i] == BUF_DRIVE;
         up = margin_up_input & r.margin_sel[i];
         dn = margin_down_input & r.margin_sel[i];
         // margin up checked first so both high stays defined
         if (up) begin
            target = r.lower_code_limit[i];
         end else if (dn) begin
            target = r.upper_code_limit[i];
         end else begin
            target = clip(r.channel_code_register[i], r.lower_code_limit[i],
                          r.upper_code_limit[i]);
         end
         next_r.applied[i] = target;
         next_r.margin_act[i] = up | dn;
         next_r.clipped[i] = ~(up | dn) & (target != r.channel_code_register[i]);

         // inverted limits hold the buffer off whatever the enable says
         ok = r.enable[i] & ~hiz_v[i];
         unique case (r.buf_st[i])
            BUF_OFF: begin
               next_r.timer[i] = 9'h000;
               if (ok) begin
                  next_r.buf_st[i] = BUF_TRACK;
               end
            end
            BUF_TRACK: begin
               next_r.timer[i] = r.timer[i] + 9'h001;
               if (!ok) begin
                  next_r.buf_st[i] = BUF_OFF;
               end else if (r.timer[i] == TRACK_LAST) begin
                  next_r.buf_st[i] = BUF_DRIVE;
               end
            end
            BUF_DRIVE: begin
               if (!ok) begin
                  next_r.buf_st[i] = BUF_OFF;
               end
            end
            default: begin
               next_r.buf_st[i] = BUF_OFF;
            end
         endcase
      end

      // read data captured on the waiting cycle, shown on the answer cycle
      ch = chan_of(avs_address);
      if (is_chan(avs_address)) begin
         unique case (avs_address[1:0])
            FLD_CODE: rd[7:0] = r.channel_code_register[ch];
            FLD_LOWER: rd[7:0] = r.lower_code_limit[ch];
            FLD_UPPER: rd[7:0] = r.upper_code_limit[ch];
            FLD_CTRL: begin
               rd[CTRL_RANGE_LSB +: 2] = r.range_sel[ch];
               rd[CTRL_ENABLE_BIT] = r.enable[ch];
               rd[CTRL_MARGIN_BIT] = r.margin_sel[ch];
            end
         endcase
      end else if (avs_address == STATUS_INDEX) begin
         rd[STAT_DRIVE_LSB +: NUM_CH] = drive_v;
         rd[STAT_HIZ_LSB +: NUM_CH] = hiz_v;
         rd[STAT_MARGIN_LSB +: NUM_CH] = r.margin_act;
         rd[STAT_CLIP_LSB +: NUM_CH] = r.clipped;
      end
      if (avs_read & ~r.ack) begin
         next_r.rdata = rd;
      end

      // writes land on the answer edge; only byte lane 0 carries data
      if (avs_write & r.ack & avs_byteenable[0] & is_chan(avs_address)) begin
         unique case (avs_address[1:0])
            FLD_CODE: next_r.channel_code_register[ch] = avs_writedata[7:0];
            FLD_LOWER: next_r.lower_code_limit[ch] = avs_writedata[7:0];
            FLD_UPPER: next_r.upper_code_limit[ch] = avs_writedata[7:0];
            FLD_CTRL: begin
               next_r.range_sel[ch] = avs_writedata[CTRL_RANGE_LSB +: 2];
               next_r.enable[ch] = avs_writedata[CTRL_ENABLE_BIT];
               next_r.margin_sel[ch] = avs_writedata[CTRL_MARGIN_BIT];
            end
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         r.channel_code_register <= {NUM_CH{CODE_RST}};
         r.lower_code_limit <= {NUM_CH{LOWER_RST}};
         r.upper_code_limit <= {NUM_CH{UPPER_RST}};
         r.range_sel <= {NUM_CH{RANGE_RST}};
         r.enable <= '0;
         r.margin_sel <= '0;
         r.buf_st <= '{default: BUF_OFF};
         r.timer <= '0;
         r.applied <= {NUM_CH{CODE_RST}};
         r.clipped <= '0;
         r.margin_act <= '0;
         r.ack <= 1'b0;
         r.rdata <= 32'h0000_0000;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // bus answer: waitrequest drops one cycle after a request appears
   assign avs_waitrequest = (avs_read | avs_write) & ~r.ack;
   assign avs_readdata = r.rdata;

   // ==========================================================
   // per-channel outputs and level converters
   dac_level_if lvl_if[NUM_CH] ();

   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
         assign lvl_if[g].code = r.applied[g];
         assign lvl_if[g].range_sel = r.range_sel[g];
         assign dac_level_uv[g] = lvl_if[g].level_uv;
         assign dac_code[g] = r.applied[g];
         // tracking keeps the buffer input on the pin, output stage off
         assign buf_track[g] = r.buf_st[g] != BUF_OFF;
         assign buf_sel_dac[g] = r.buf_st[g] == BUF_DRIVE;
         assign buf_drive[g] = r.buf_st[g] == BUF_DRIVE;

         dac_level u_level (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .lvl(lvl_if[g].conv)
         );

         chk_margin_up: assert property (@(posedge ref_clk) disable iff (!nrst)
            margin_up_input && r.margin_sel[g] |=> dac_code[g] == $past(r.lower_code_limit[g]))
            else $error("margin up did not apply the lower limit");

         chk_margin_down: assert property (@(posedge ref_clk) disable iff (!nrst)
            !margin_up_input && margin_down_input && r.margin_sel[g]
            |=> dac_code[g] == $past(r.upper_code_limit[g]))
            else $error("margin down did not apply the upper limit");

         chk_up_priority: assert property (@(posedge ref_clk) disable iff (!nrst)
            margin_up_input && margin_down_input && r.margin_sel[g]
            |=> r.margin_act[g] && dac_code[g] == $past(r.lower_code_limit[g]))
            else $error("margin up lost priority");

         chk_clip_range: assert property (@(posedge ref_clk) disable iff (!nrst)
            !r.margin_sel[g] && r.lower_code_limit[g] <= r.upper_code_limit[g]
            |=> dac_code[g] >= $past(r.lower_code_limit[g])
                && dac_code[g] <= $past(r.upper_code_limit[g]))
            else $error("applied code outside the limits");

         chk_hiz_limits: assert property (@(posedge ref_clk) disable iff (!nrst)
            r.lower_code_limit[g] > r.upper_code_limit[g] |=> !buf_drive[g] && !buf_track[g])
            else $error("buffer on with inverted limits");

         chk_track_first: assert property (@(posedge ref_clk) disable iff (!nrst)
            $rose(buf_drive[g]) |-> $past(buf_track[g]) && !$past(buf_sel_dac[g]))
            else $error("buffer drove without tracking first");

         chk_track_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
            $rose(buf_track[g]) |-> !buf_drive[g] [*8])
            else $error("tracking phase cut short");

         // the counter shows the whole tracking time, not just its first cycles
         chk_track_len: assert property (@(posedge ref_clk) disable iff (!nrst)
            $rose(buf_drive[g]) |-> $past(r.timer[g]) == TRACK_LAST)
            else $error("tracking time differs from the set count");

         chk_disable_off: assert property (@(posedge ref_clk) disable iff (!nrst)
            !r.enable[g] |=> !buf_drive[g] && !buf_track[g])
            else $error("buffer stayed on after disable");

         cov_margin_up: cover property (@(posedge ref_clk) disable iff (!nrst)
            r.margin_act[g] && margin_up_input);
         cov_drive: cover property (@(posedge ref_clk) disable iff (!nrst)
            $rose(buf_drive[g]));
         cov_clip: cover property (@(posedge ref_clk) disable iff (!nrst)
            r.clipped[g]);
      end
   endgenerate

   // ==========================================================
   // bus checks
   chk_wait_release: assert property (@(posedge ref_clk) disable iff (!nrst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held longer than one cycle");

   chk_code_write: assert property (@(posedge ref_clk) disable iff (!nrst)
      avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[1:0] == FLD_CODE
      && is_chan(avs_address)
      |=> r.channel_code_register[$past(chan_of(avs_address))] == $past(avs_writedata[7:0]))
      else $error("code write not stored");

   cov_margin_down: cover property (@(posedge ref_clk) disable iff (!nrst)
      margin_down_input && !margin_up_input && |r.margin_act);

endmodule

// ---- test/fb_node.sv ----
// feedback node of a dc-to-dc converter seen through the attenuation resistor
// assumes levels in uV from margining_dac_control, all in the ref_clk domain
`timescale 1ns/100ps
module fb_node
   import margin_pkg::*;
#(
   parameter logic [20:0] FB_UV = 21'h927C0
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [NUM_CH-1:0][20:0] dac_level_uv,
   input wire logic [NUM_CH-1:0] buf_track,
   input wire logic [NUM_CH-1:0] buf_drive,
   output logic [NUM_CH-1:0][20:0] pin_uv,
   output logic [7:0] glitch_count
);
   // ==========================================================
   // pin model
   logic [NUM_CH-1:0] track_d;
   logic [NUM_CH-1:0] drive_d;
   // undriven pin sits at the converter's own feedback voltage
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         pin_uv[i] = buf_drive[i] ? dac_level_uv[i] : FB_UV;
      end
   end
   // drive without prior tracking, or onto a different level, kicks the node
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         track_d <= '0;
         drive_d <= '0;
         glitch_count <= 8'h00;
      end else begin
         track_d <= buf_track;
         drive_d <= buf_drive;
         for (int i = 0; i < NUM_CH; i++) begin
            if (buf_drive[i] && !drive_d[i] && (!track_d[i] || dac_level_uv[i] !== FB_UV)) begin
               glitch_count <= glitch_count + 8'h01;
            end
         end
      end
   end
endmodule

// ---- test/tb_margining_dac_control.sv ----
// self-checking bench for margining_dac_control over avalon-mm
// assumes margin_pkg compiled first; fb_node models the converter side
`timescale 1ns/100ps
module tb_margining_dac_control
   import margin_pkg::*;
;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic margin_up_input = 1'b0;
   logic margin_down_input = 1'b0;
   logic [NUM_CH-1:0][7:0] dac_code;
   logic [NUM_CH-1:0][20:0] dac_level_uv;
   logic [NUM_CH-1:0] buf_track;
   logic [NUM_CH-1:0] buf_sel_dac;
   logic [NUM_CH-1:0] buf_drive;
   logic [NUM_CH-1:0][20:0] pin_uv;
   logic [7:0] glitch_count;
   int fail_count = 0;
   int cmp_count = 0;
   logic [31:0] spare_q;
   logic [7:0] codes [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
   logic [20:0] mids [4] = '{MID_0V6_UV, MID_0V8_UV, MID_1V0_UV, MID_1V25_UV};

   // ==========================================================
   // clock, design and converter model
   always #10 ref_clk = ~ref_clk;
   margining_dac_control uut (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .margin_up_input(margin_up_input),
      .margin_down_input(margin_down_input), .dac_code(dac_code), .dac_level_uv(dac_level_uv),
      .buf_track(buf_track), .buf_sel_dac(buf_sel_dac), .buf_drive(buf_drive));
   fb_node fb (.ref_clk(ref_clk), .nrst(nrst), .dac_level_uv(dac_level_uv),
      .buf_track(buf_track), .buf_drive(buf_drive), .pin_uv(pin_uv),
      .glitch_count(glitch_count));

   // ==========================================================
   // helpers
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_lvl(input logic [20:0] got, input logic [20:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t level got %h exp %h", $time, got, exp);
      end
   endtask
   // one avalon access; waitrequest is sampled at the edge, never assumed
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
         input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk_word(32'hDEAD, 32'h0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      chk_word(q, exp);
   endtask
   function automatic logic [4:0] ad(input int ch, input logic [1:0] f);
      return {3'(ch), f};
   endfunction
   // level in uV, truncated toward zero
   function automatic logic [20:0] exp_lvl(input logic [7:0] c, input int r);
      return 21'(int'(mids[r]) + (int'(c) - 127) * 601500 / 255);
   endfunction
   task automatic settle();
      repeat (3) @(posedge ref_clk);
   endtask

   // ==========================================================
   // watchdog: tests need under a thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      conclude();
   end

   // ==========================================================
   // test sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < NUM_CH; i++) begin
         chk_word(32'(dac_code[i]), 32'h7F);
         chk_lvl(dac_level_uv[i], MID_0V6_UV);
      end
      rd(ad(0, FLD_CODE), 32'h7F);
      rd(ad(0, FLD_LOWER), 32'h00);
      rd(ad(0, FLD_UPPER), 32'hFF);
      rd(ad(0, FLD_CTRL), 32'h0);
      rd(5'h1F, 32'h0);
      wr(5'h1F, 32'h55);
      bus(1'b1, ad(0, FLD_CODE), 32'h11, 4'h0, spare_q);
      rd(ad(0, FLD_CODE), 32'h7F);
      $display("test reset_and_map done");
      // every range and the code extremes, back to back writes
      for (int r = 0; r < 4; r++) begin
         wr(ad(3, FLD_CTRL), r);
         for (int k = 0; k < 4; k++) begin
            wr(ad(3, FLD_CODE), 32'(codes[k]));
            settle();
            chk_word(dac_code[3], codes[k]);
            chk_lvl(dac_level_uv[3], exp_lvl(codes[k], r));
         end
      end
      $display("test ranges done");
      // clipping at both limits and a pass-through code
      wr(ad(0, FLD_LOWER), 32'h20);
      wr(ad(0, FLD_UPPER), 32'hE0);
      for (int k = 0; k < 3; k++) begin
         wr(ad(0, FLD_CODE), k == 0 ? 32'h10 : k == 1 ? 32'hF0 : 32'h50);
         settle();
         chk_word(dac_code[0], k == 0 ? 32'h20 : k == 1 ? 32'hE0 : 32'h50);
      end
      $display("test clipping done");
      // margin pins on channel 1 only
      wr(ad(1, FLD_LOWER), 32'h30);
      wr(ad(1, FLD_UPPER), 32'hD0);
      wr(ad(1, FLD_CTRL), 32'h8);
      for (int k = 1; k < 4; k++) begin
         margin_up_input <= k[0];
         margin_down_input <= k[1];
         settle();
         chk_word(dac_code[1], k[0] ? 32'h30 : 32'hD0);
         chk_lvl(dac_level_uv[1], exp_lvl(k[0] ? 8'h30 : 8'hD0, 0));
         chk_word(dac_code[0], 32'h50);
      end
      margin_up_input <= 1'b0;
      margin_down_input <= 1'b0;
      settle();
      chk_word(dac_code[1], 32'h7F);
      $display("test margin done");
      // host disables, loads the feedback code, then enables
      wr(ad(2, FLD_CTRL), 32'h0);
      wr(ad(2, FLD_CODE), 32'h7F);
      wr(ad(2, FLD_CTRL), 32'h4);
      repeat (2) @(posedge ref_clk);
      chk_word({buf_track[2], buf_sel_dac[2], buf_drive[2]}, 32'h4);
      repeat (490) @(posedge ref_clk);
      chk_word({buf_track[2], buf_sel_dac[2], buf_drive[2]}, 32'h4);
      repeat (20) @(posedge ref_clk);
      chk_word({buf_track[2], buf_sel_dac[2], buf_drive[2]}, 32'h7);
      chk_lvl(pin_uv[2], MID_0V6_UV);
      chk_word(glitch_count, 32'h0);
      rd(STATUS_INDEX, 32'h4);
      wr(ad(2, FLD_LOWER), 32'h90);
      wr(ad(2, FLD_UPPER), 32'h80);
      settle();
      chk_word({buf_track[2], buf_sel_dac[2], buf_drive[2]}, 32'h0);
      // code 0x7F now sits below the new lower limit, so it reads as clipped too
      rd(STATUS_INDEX, 32'h0400_0400);
      $display("test buffer done");
      conclude();
   end
endmodule
